/* logic/hpsr_pkg.sv */
/*
 High-page system register bank: offsets, field positions, reset values and carriers.
 Assumes a classic Wishbone slave with 32-bit data, one register per aligned word.
*/
package hpsr_pkg;
    // Printed offsets are not multiples of four: index = offset, byte address = 4 * index
    localparam logic [15:0] IDX_BREAK_FLAGS = 16'hFE00;
    localparam logic [15:0] IDX_RESET_CAUSE = 16'hFE01;
    localparam logic [15:0] IDX_BREAK_AUX = 16'hFE02;
    localparam logic [15:0] IDX_BREAK_FLAG_CTL = 16'hFE03;
    localparam logic [15:0] IDX_IRQ_SRC_A = 16'hFE04;
    localparam logic [15:0] IDX_IRQ_SRC_B = 16'hFE05;
    localparam logic [15:0] IDX_IRQ_SRC_C = 16'hFE06;
    localparam logic [15:0] IDX_RSVD_FE07 = 16'hFE07;
    localparam logic [15:0] IDX_NVM_CONTROL = 16'hFE08;
    localparam logic [15:0] IDX_BREAK_ADDR_HIGH = 16'hFE09;
    localparam logic [15:0] IDX_BREAK_ADDR_LOW = 16'hFE0A;
    localparam logic [15:0] IDX_BREAK_CONTROL = 16'hFE0B;
    localparam logic [15:0] IDX_LOW_VOLT_STATUS = 16'hFE0C;
    localparam logic [15:0] IDX_RSVD_NVM_TEST = 16'hFE0D;
    localparam logic [15:0] IDX_NVM_BLOCK_PROT = 16'hFFBE;
    localparam logic [15:0] IDX_RSVD_FFBF = 16'hFFBF;
    localparam logic [15:0] IDX_OSC_TRIM = 16'hFFC0;
    localparam logic [15:0] IDX_RSVD_FFC1 = 16'hFFC1;
    localparam logic [15:0] IDX_WDOG_SERVICE = 16'hFFFF;
    // Own additions: sticky event status and its mask
    localparam logic [15:0] IDX_EVENT_STATUS = 16'hFE10;
    localparam logic [15:0] IDX_EVENT_MASK = 16'hFE11;

    // Field positions
    localparam int BIT_SW_BREAK = 1;
    localparam int BIT_BREAK_WDOG_DIS = 0;
    localparam int BIT_BREAK_CLR_EN = 7;
    localparam int BIT_BREAK_ENABLE = 7;
    localparam int BIT_BREAK_ACTIVE = 6;
    localparam int BIT_LV_OUT = 7;
    localparam int BIT_HV_ENABLE = 3;
    localparam int BIT_MASS = 2;
    localparam int BIT_ERASE = 1;
    localparam int BIT_WRITE_SEL = 0;
    localparam logic [7:0] MASK_IRQ_A = 8'h74;
    localparam logic [7:0] MASK_IRQ_B = 8'h80;
    localparam logic [7:0] MASK_IRQ_C = 8'h01;
    localparam logic [7:0] MASK_RESET_CAUSE = 8'hFE;
    localparam logic [7:0] MASK_NVM_CONTROL = 8'h0F;

    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_RESET_CAUSE = 8'h80;

    // Event status bits
    localparam int EV_SW_BREAK = 0;
    localparam int EV_WDOG_SERVICE = 1;
    localparam int EV_LOW_VOLT = 2;
    localparam int EV_NVM_REFUSED = 3;
    localparam int EV_COUNT = 4;

    typedef struct packed {
        logic [7:0] bprot;
        logic [7:0] trim;
    } hpsr_nv_t;

    typedef struct packed {
        logic wdogDisable;
        logic swBreak;
        logic clearFlagEnable;
        logic breakEnable;
        logic breakActive;
    } hpsr_break_t;
endpackage

/* logic/hpsr_regs.sv */
/*
 High-page system register bank as a classic Wishbone slave.
 Assumes a synchronous single-clock system; nonvolatile values arrive preloaded on
 nvLoad at power-up and are kept by this bank across every later reset.
*/
// Design decision made here: the Wishbone register port.
// Summary of operation
// - Writing zero to bit 1 of break_flags clears the software break flag.
// - reset_cause holds read-only cause flags in bits 7..1, bit 0 zero, only bit 7 set after power-on.
// - irq_source_flags_a shows read-only sources at bits 6,5,4,2, others zero, reset zero.
// - irq_source_flags_b shows a read-only source at bit 7, others zero, reset zero.
// - irq_source_flags_c shows a read-only source at bit 0, others zero, reset zero.
// - Reading the watchdog service location returns the low byte of the reset vector.
// - Any write to the watchdog service location clears the watchdog counter.
// - The block-protect bits keep their stored value through any reset.
// - The oscillator trim byte is held nonvolatile, readable, and untouched by reset.
// - low_voltage_status shows the detector output in bit 7, others zero, reset zero.
// - break_control holds break enable and break active, both reset zero, others zero.
// - The nonvolatile test locations are reserved and have no register behaviour.
// - Erase select and write-cycle select are never both set.
// - High-voltage enable sets only when write-cycle or erase select is already set.
`timescale 1ns/1ps
module hpsr_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Wishbone slave
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Status sources from the system
    input wire logic [6:0] resetCauseIn,
    input wire logic resetCauseLoad,
    input wire logic extIrqSourceFlag,
    input wire logic timerCh0SourceFlag,
    input wire logic timerCh1SourceFlag,
    input wire logic timerOverflowSourceFlag,
    input wire logic keypadSourceFlag,
    input wire logic converterDoneSourceFlag,
    input wire logic lowVoltageDetectOutput,
    input wire logic swBreakSet,
    input wire logic breakActiveSet,
    input wire logic [7:0] resetVectorLow,
    // Nonvolatile contents, presented once at power-up
    input wire hpsr_pkg::hpsr_nv_t nvLoad,
    input wire logic nvLoadStrobe,
    // Controls out
    output hpsr_pkg::hpsr_break_t breakCtl,
    output logic [15:0] breakAddr,
    output logic [3:0] nvmCtl,
    output hpsr_pkg::hpsr_nv_t nvValue,
    output logic wdogClear,
    output logic irq
);
    logic [7:0] resetCause_reg;
    logic [7:0] irqA_reg, irqB_reg, irqC_reg, lowVolt_reg;
    logic [7:0] brkHigh_reg, brkLow_reg;
    logic [3:0] nvm_reg;
    logic [7:0] bprot_reg, trim_reg;
    hpsr_pkg::hpsr_break_t brk_reg;
    logic [hpsr_pkg::EV_COUNT-1:0] evStatus_reg, evMask_reg, evSet;
    logic lowVoltPrev_reg;
    logic [31:0] rdata;
    logic hit;

    wire logic [15:0] idx = wb_adr_i[17:2];
    wire logic req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire logic wr = req & wb_we_i & wb_sel_i[0] & hit;
    wire logic rd = req & ~wb_we_i & hit;
    wire logic [7:0] wd = wb_dat_i[7:0];

    // Read mux and decode; reserved locations answer with zeros
    always_comb begin
        hit = 1'b1;
        rdata = 32'h0000_0000;
        unique case (idx)
            hpsr_pkg::IDX_BREAK_FLAGS: rdata[hpsr_pkg::BIT_SW_BREAK] = brk_reg.swBreak;
            hpsr_pkg::IDX_RESET_CAUSE: rdata[7:0] = resetCause_reg & hpsr_pkg::MASK_RESET_CAUSE;
            hpsr_pkg::IDX_BREAK_AUX: rdata[hpsr_pkg::BIT_BREAK_WDOG_DIS] = brk_reg.wdogDisable;
            hpsr_pkg::IDX_BREAK_FLAG_CTL: rdata[hpsr_pkg::BIT_BREAK_CLR_EN] = brk_reg.clearFlagEnable;
            hpsr_pkg::IDX_IRQ_SRC_A: rdata[7:0] = irqA_reg & hpsr_pkg::MASK_IRQ_A;
            hpsr_pkg::IDX_IRQ_SRC_B: rdata[7:0] = irqB_reg & hpsr_pkg::MASK_IRQ_B;
            hpsr_pkg::IDX_IRQ_SRC_C: rdata[7:0] = irqC_reg & hpsr_pkg::MASK_IRQ_C;
            hpsr_pkg::IDX_NVM_CONTROL: rdata[3:0] = nvm_reg;
            hpsr_pkg::IDX_BREAK_ADDR_HIGH: rdata[7:0] = brkHigh_reg;
            hpsr_pkg::IDX_BREAK_ADDR_LOW: rdata[7:0] = brkLow_reg;
            hpsr_pkg::IDX_BREAK_CONTROL: begin
                rdata[hpsr_pkg::BIT_BREAK_ENABLE] = brk_reg.breakEnable;
                rdata[hpsr_pkg::BIT_BREAK_ACTIVE] = brk_reg.breakActive;
            end
            hpsr_pkg::IDX_LOW_VOLT_STATUS: rdata[7:0] = lowVolt_reg;
            hpsr_pkg::IDX_NVM_BLOCK_PROT: rdata[7:0] = bprot_reg;
            hpsr_pkg::IDX_OSC_TRIM: rdata[7:0] = trim_reg;
            hpsr_pkg::IDX_WDOG_SERVICE: rdata[7:0] = resetVectorLow;
            hpsr_pkg::IDX_EVENT_STATUS: rdata[hpsr_pkg::EV_COUNT-1:0] = evStatus_reg;
            hpsr_pkg::IDX_EVENT_MASK: rdata[hpsr_pkg::EV_COUNT-1:0] = evMask_reg;
            hpsr_pkg::IDX_RSVD_FE07, hpsr_pkg::IDX_RSVD_NVM_TEST,
            hpsr_pkg::IDX_RSVD_FFBF, hpsr_pkg::IDX_RSVD_FFC1: rdata = 32'h0000_0000;
            default: hit = 1'b0;
        endcase
    end

    // Bus answer: one cycle after the request, dropped the cycle after
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req & hit;
            wb_err_o <= req & ~hit;
            wb_dat_o <= (req & hit & ~wb_we_i) ? rdata : 32'h0000_0000;
        end
    end

    // Reset cause: power-on value, then loaded by the reset controller
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            resetCause_reg <= hpsr_pkg::RST_RESET_CAUSE;
        end else if (resetCauseLoad) begin
            resetCause_reg <= {resetCauseIn, 1'b0};
        end
    end

    // Interrupt source and low-voltage mirrors
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irqA_reg <= hpsr_pkg::RST_ZERO;
            irqB_reg <= hpsr_pkg::RST_ZERO;
            irqC_reg <= hpsr_pkg::RST_ZERO;
            lowVolt_reg <= hpsr_pkg::RST_ZERO;
        end else begin
            irqA_reg <= {1'b0, timerOverflowSourceFlag, timerCh1SourceFlag, timerCh0SourceFlag,
                         1'b0, extIrqSourceFlag, 2'b00};
            irqB_reg <= {keypadSourceFlag, 7'h00};
            irqC_reg <= {7'h00, converterDoneSourceFlag};
            lowVolt_reg <= {lowVoltageDetectOutput, 7'h00};
        end
    end

    // Break registers; hardware set beats a software clear in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            brk_reg <= '0;
            brkHigh_reg <= hpsr_pkg::RST_ZERO;
            brkLow_reg <= hpsr_pkg::RST_ZERO;
        end else begin
            if (swBreakSet) begin
                brk_reg.swBreak <= 1'b1;
            end else if (wr && idx == hpsr_pkg::IDX_BREAK_FLAGS && !wd[hpsr_pkg::BIT_SW_BREAK]) begin
                brk_reg.swBreak <= 1'b0;
            end
            if (wr && idx == hpsr_pkg::IDX_BREAK_AUX) begin
                brk_reg.wdogDisable <= wd[hpsr_pkg::BIT_BREAK_WDOG_DIS];
            end
            if (wr && idx == hpsr_pkg::IDX_BREAK_FLAG_CTL) begin
                brk_reg.clearFlagEnable <= wd[hpsr_pkg::BIT_BREAK_CLR_EN];
            end
            if (wr && idx == hpsr_pkg::IDX_BREAK_CONTROL) begin
                brk_reg.breakEnable <= wd[hpsr_pkg::BIT_BREAK_ENABLE];
            end
            if (breakActiveSet) begin
                brk_reg.breakActive <= 1'b1;
            end else if (wr && idx == hpsr_pkg::IDX_BREAK_CONTROL) begin
                brk_reg.breakActive <= wd[hpsr_pkg::BIT_BREAK_ACTIVE];
            end
            if (wr && idx == hpsr_pkg::IDX_BREAK_ADDR_HIGH) begin
                brkHigh_reg <= wd;
            end
            if (wr && idx == hpsr_pkg::IDX_BREAK_ADDR_LOW) begin
                brkLow_reg <= wd;
            end
        end
    end

    // Nonvolatile control with erase/program interlock
    wire logic nvmWr = wr && idx == hpsr_pkg::IDX_NVM_CONTROL;
    wire logic selBoth = wd[hpsr_pkg::BIT_ERASE] & wd[hpsr_pkg::BIT_WRITE_SEL];
    wire logic selHeld = nvm_reg[hpsr_pkg::BIT_ERASE] | nvm_reg[hpsr_pkg::BIT_WRITE_SEL];
    wire logic hvRefused = nvmWr & wd[hpsr_pkg::BIT_HV_ENABLE]
                           & ~nvm_reg[hpsr_pkg::BIT_HV_ENABLE] & ~selHeld;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nvm_reg <= 4'h0;
        end else if (nvmWr) begin
            nvm_reg[hpsr_pkg::BIT_MASS] <= wd[hpsr_pkg::BIT_MASS];
            // Both selects requested: keep the old pair rather than guess
            if (!selBoth) begin
                nvm_reg[hpsr_pkg::BIT_ERASE] <= wd[hpsr_pkg::BIT_ERASE];
                nvm_reg[hpsr_pkg::BIT_WRITE_SEL] <= wd[hpsr_pkg::BIT_WRITE_SEL];
            end
            nvm_reg[hpsr_pkg::BIT_HV_ENABLE] <= wd[hpsr_pkg::BIT_HV_ENABLE] & ~hvRefused;
        end
    end

    // Nonvolatile store: not in the reset list, loaded by its strobe, otherwise written by the bus
    always_ff @(posedge clk) begin
        if (nvLoadStrobe) begin
            bprot_reg <= nvLoad.bprot;
            trim_reg <= nvLoad.trim;
        end else begin
            if (wr && idx == hpsr_pkg::IDX_NVM_BLOCK_PROT) begin
                bprot_reg <= wd;
            end
            if (wr && idx == hpsr_pkg::IDX_OSC_TRIM) begin
                trim_reg <= wd;
            end
        end
    end

    // Watchdog service pulse, any data value
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wdogClear <= 1'b0;
        end else begin
            wdogClear <= req & wb_we_i & (idx == hpsr_pkg::IDX_WDOG_SERVICE);
        end
    end

    // Sticky events: a read of the status clears it, a new event wins
    always_comb begin
        evSet = '0;
        evSet[hpsr_pkg::EV_SW_BREAK] = swBreakSet;
        evSet[hpsr_pkg::EV_WDOG_SERVICE] = req & wb_we_i & (idx == hpsr_pkg::IDX_WDOG_SERVICE);
        evSet[hpsr_pkg::EV_LOW_VOLT] = lowVoltageDetectOutput & ~lowVoltPrev_reg;
        evSet[hpsr_pkg::EV_NVM_REFUSED] = hvRefused | (nvmWr & selBoth);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            evStatus_reg <= '0;
            evMask_reg <= '0;
            lowVoltPrev_reg <= 1'b0;
            irq <= 1'b0;
        end else begin
            lowVoltPrev_reg <= lowVoltageDetectOutput;
            if (rd && idx == hpsr_pkg::IDX_EVENT_STATUS) begin
                evStatus_reg <= evSet;
            end else begin
                evStatus_reg <= evStatus_reg | evSet;
            end
            if (wr && idx == hpsr_pkg::IDX_EVENT_MASK) begin
                evMask_reg <= wd[hpsr_pkg::EV_COUNT-1:0];
            end
            irq <= |((evStatus_reg | evSet) & evMask_reg);
        end
    end

    // Control outputs, registered
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            breakCtl <= '0;
            breakAddr <= 16'h0000;
            nvmCtl <= 4'h0;
            nvValue <= '0;
        end else begin
            breakCtl <= brk_reg;
            breakAddr <= {brkHigh_reg, brkLow_reg};
            nvmCtl <= nvm_reg;
            nvValue <= {bprot_reg, trim_reg};
        end
    end
endmodule

/* verif/hpsr_regs_asserts.sv */
/*
 Port-level assertions for the high-page system register bank.
 Assumes one clock, an asynchronous active-low reset and a one-cycle registered answer.
*/
`timescale 1ns/1ps
module hpsr_regs_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Bus
    input wire logic [31:0] wb_adr_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // System side
    input wire logic [7:0] resetVectorLow,
    input wire logic [3:0] nvmCtl,
    input wire logic wdogClear
);
    logic take;
    logic [15:0] idx;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign idx = wb_adr_i[17:2];
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_answer_next: assert property (take |=> (wb_ack_o || wb_err_o))
        else $error("request not answered in one cycle");
    a_wdog_clear: assert property (take && wb_we_i && idx == 16'hFFFF |=> wdogClear)
        else $error("watchdog clear missing after service write");
    a_wdog_read: assert property (take && !wb_we_i && idx == 16'hFFFF
        |=> wb_dat_o == {24'h000000, $past(resetVectorLow)})
        else $error("service location read not the vector byte");
    a_nvm_interlock: assert property (!(nvmCtl[1] && nvmCtl[0]))
        else $error("erase and write select both set");
    a_hv_gated: assert property ($rose(nvmCtl[3]) |-> $past(nvmCtl[1] || nvmCtl[0]))
        else $error("high voltage set without a select bit");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read data not zero");
    a_rsvd_zero: assert property (take && idx == 16'hFE07 |=> wb_ack_o && wb_dat_o == 32'h0)
        else $error("reserved location not answered with zero");
    a_irq_a_bits: assert property (take && !wb_we_i && idx == 16'hFE04
        |=> (wb_dat_o[7:0] & ~8'h74) == 8'h00)
        else $error("unused source bits not zero");
endmodule

bind hpsr_regs hpsr_regs_asserts u_chk (.clk, .rst_b, .wb_adr_i, .wb_we_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .resetVectorLow, .nvmCtl, .wdogClear);

/* verif/tb_top.sv */
/*
 Self-checking bench for the high-page system register bank.
 Assumes hpsr_pkg and hpsr_regs are compiled first; the bench drives every port.
*/
`timescale 1ns/1ps
module tb_top;
    logic clk, rst_b, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o, wdogClear, irq;
    logic lowVoltageDetectOutput, gotErr;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, got;
    logic [3:0] wb_sel_i, pls, nvmCtl, n;
    logic [6:0] resetCauseIn;
    logic [5:0] src;
    logic [7:0] resetVectorLow, d;
    logic [15:0] breakAddr;
    hpsr_pkg::hpsr_nv_t nvLoad, nvValue;
    hpsr_pkg::hpsr_break_t breakCtl;
    logic [3:0] nvmModel;
    logic [15:0] zeroIdx [10] = '{16'hFE04, 16'hFE05, 16'hFE06, 16'hFE07, 16'hFE08, 16'hFE09,
        16'hFE0A, 16'hFE0B, 16'hFE0C, 16'hFE0D};
    int fails, samplesChecked;

    hpsr_regs DUT (.clk, .rst_b, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
        .wb_dat_o, .wb_ack_o, .wb_err_o, .resetCauseIn, .resetCauseLoad(pls[0]),
        .extIrqSourceFlag(src[0]), .timerCh0SourceFlag(src[1]), .timerCh1SourceFlag(src[2]),
        .timerOverflowSourceFlag(src[3]), .keypadSourceFlag(src[4]),
        .converterDoneSourceFlag(src[5]), .lowVoltageDetectOutput, .swBreakSet(pls[2]),
        .breakActiveSet(pls[3]), .resetVectorLow, .nvLoad, .nvLoadStrobe(pls[1]), .breakCtl,
        .breakAddr, .nvmCtl, .nvValue, .wdogClear, .irq);

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic endOfTest();
        if (fails == 0 && samplesChecked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One classic cycle; held until ack or err is sampled high
    task automatic bus(input logic [15:0] idx, input logic w, input logic [7:0] v);
        int k;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_adr_i <= {14'h0000, idx, 2'b00};
        wb_we_i <= w;
        wb_dat_i <= {24'h000000, v};
        wb_sel_i <= 4'hF;
        k = 0;
        @(posedge clk);
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && k < 20) begin
            k++;
            @(posedge clk);
        end
        got = wb_dat_o;
        gotErr = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (k == 20) begin
            fails++;
            endOfTest();
        end
    endtask

    task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input string name);
        bus(idx, 1'b0, 8'h00);
        check(name, got, exp);
    endtask

    task automatic pulse(input int b);
        @(posedge clk);
        pls[b] <= 1'b1;
        @(posedge clk);
        pls[b] <= 1'b0;
    endtask

    task automatic doReset();
        rst_b <= 1'b0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        {rst_b, wb_we_i, wb_cyc_i, wb_stb_i, lowVoltageDetectOutput} = 5'h00;
        {wb_adr_i, wb_dat_i, wb_sel_i, pls, src, resetVectorLow} = 0;
        {fails, samplesChecked, nvmModel} = 0;
        void'($urandom(7));
        nvLoad = 16'($urandom);
        resetCauseIn = 7'($urandom);
        doReset();
        pulse(1);
        rd(16'hFFBE, {24'h0, nvLoad.bprot}, "block_protect");
        rd(16'hFFC0, {24'h0, nvLoad.trim}, "osc_trim");
        rd(16'hFE01, 32'h80, "reset_cause");
        foreach (zeroIdx[i]) rd(zeroIdx[i], 32'h0, "reset_zero");
        pulse(0);
        rd(16'hFE01, {24'h0, resetCauseIn, 1'b0}, "reset_cause_load");
        repeat (4) begin
            src <= 6'($urandom);
            lowVoltageDetectOutput <= 1'($urandom);
            repeat (2) @(posedge clk);
            rd(16'hFE04, {25'h0, src[3:1], 1'b0, src[0], 2'b00}, "irq_a");
            rd(16'hFE05, {24'h0, src[4], 7'h00}, "irq_b");
            rd(16'hFE06, {31'h0, src[5]}, "irq_c");
            rd(16'hFE0C, {24'h0, lowVoltageDetectOutput, 7'h00}, "low_volt");
        end
        // Expected byte taken from d: the port only updates after this time step
        d = 8'($urandom);
        resetVectorLow <= d;
        rd(16'hFFFF, {24'h0, d}, "wdog_read");
        bus(16'hFFFF, 1'b1, 8'($urandom));
        check("wdog_clear", {31'h0, wdogClear}, 32'h1);
        pulse(2);
        rd(16'hFE00, 32'h02, "sw_break_set");
        bus(16'hFE00, 1'b1, 8'hFD);
        rd(16'hFE00, 32'h00, "sw_break_clear");
        bus(16'hFE0B, 1'b1, 8'hFF);
        rd(16'hFE0B, 32'hC0, "break_control");
        bus(16'hFE0B, 1'b1, 8'h00);
        pulse(3);
        rd(16'hFE0B, 32'h40, "break_active");
        check("break_ctl_out", {27'h0, breakCtl}, 32'h01);
        d = 8'($urandom);
        bus(16'hFE09, 1'b1, d);
        rd(16'hFE09, {24'h0, d}, "break_addr_high");
        check("break_addr_out", {16'h0, breakAddr}, {16'h0, d, 8'h00});
        repeat (16) begin
            d = 8'($urandom);
            bus(16'hFE08, 1'b1, d);
            n = d[3:0];
            if (n[1] && n[0]) n[1:0] = nvmModel[1:0];
            if (n[3] && !(nvmModel[3] || nvmModel[1] || nvmModel[0])) n[3] = 1'b0;
            nvmModel = n;
            rd(16'hFE08, {28'h0, nvmModel}, "nvm_control");
            check("nvm_ctl_out", {28'h0, nvmCtl}, {28'h0, nvmModel});
        end
        bus(16'hFFBE, 1'b1, 8'h5A);
        bus(16'hFFC0, 1'b1, 8'hA5);
        bus(16'hFE07, 1'b1, 8'hFF);
        rd(16'hFE07, 32'h0, "reserved");
        bus(16'h0100, 1'b0, 8'h00);
        check("unmapped_err", {31'h0, gotErr}, 32'h1);
        doReset();
        rd(16'hFFBE, 32'h5A, "block_protect_kept");
        rd(16'hFFC0, 32'hA5, "osc_trim_kept");
        check("nv_value_out", {16'h0, nvValue}, 32'h5AA5);
        rd(16'hFE08, 32'h0, "nvm_reset");
        // Events raised, masked and cleared by read
        bus(16'hFE10, 1'b0, 8'h00);
        bus(16'hFE11, 1'b1, 8'h01);
        pulse(2);
        repeat (2) @(posedge clk);
        check("irq_raised", {31'h0, irq}, 32'h1);
        rd(16'hFE10, 32'h01, "event_status");
        repeat (2) @(posedge clk);
        check("irq_cleared", {31'h0, irq}, 32'h0);
        bus(16'hFE11, 1'b1, 8'h00);
        pulse(2);
        repeat (2) @(posedge clk);
        check("irq_masked", {31'h0, irq}, 32'h0);
        endOfTest();
    end
endmodule
